/* twmt_defines.vh */
/*
 * Constants for the two-wire master transmitter: register offsets, bit
 * positions, status codes, reset values and bit timing.
 * Assumes a 125 MHz core clock and inclusion by bare name.
 */
`ifndef TWMT_DEFINES_VH
`define TWMT_DEFINES_VH

// ==========================================================
// Register offsets
`define TWMT_OFS_CTRL   2'h0
`define TWMT_OFS_STATUS 2'h1
`define TWMT_OFS_DATA   2'h2

// ==========================================================
// Control bit positions
`define TWMT_B_FLAG  7
`define TWMT_B_ACK   6
`define TWMT_B_START 5
`define TWMT_B_STOP  4
`define TWMT_B_WCOL  3
`define TWMT_B_EN    2
`define TWMT_B_IE    0

// ==========================================================
// Status codes and reset values
`define TWMT_ST_START   8'h08
`define TWMT_ST_RSTART  8'h10
`define TWMT_ST_AW_ACK  8'h18
`define TWMT_ST_AW_NACK 8'h20
`define TWMT_ST_D_ACK   8'h28
`define TWMT_ST_D_NACK  8'h30
`define TWMT_ST_LOST    8'h38
`define TWMT_ST_AR_ACK  8'h40
`define TWMT_ST_AR_NACK 8'h48
`define TWMT_ST_NONE    8'hf8
`define TWMT_RST_DATA   8'hff

// ==========================================================
// Bit timing: four quarter steps per bit
`define TWMT_CLK_MHZ     125
`define TWMT_BIT_NS      10000
`define TWMT_QTR_CYCLES  ((`TWMT_BIT_NS * `TWMT_CLK_MHZ) / 4000)

`endif

/* twmt_tick_gen.v */
/*
 * Quarter-bit enable divider for the two-wire master.
 * Assumes one clock; the tick is a one-cycle enable pulse.
 */
`timescale 1ns/1ps
module twmt_tick_gen #(
	parameter DIV = 312,
	parameter CW  = 16
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          rst_i,
	// Control and tick
	input  wire          run_i,
	output reg           tick_o
);
	reg  [CW-1:0] cnt_reg;

	// ==========================================================
	// Divider
	// Restarting while idle keeps the first step a full quarter long
	always @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_reg <= {CW{1'b0}};
			tick_o  <= 1'b0;
		end else if (cnt_reg == DIV[CW-1:0] - 1'b1) begin
			cnt_reg <= {CW{1'b0}};
			tick_o  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick_o  <= 1'b0;
		end
	end
endmodule // twmt_tick_gen

/* twmt_master_tx.v */
/*
 * Two-wire master transmitter: control, status and data registers, START,
 * address, data, repeated START and STOP generation, arbitration loss.
 * Assumes bus inputs synchronous to CORE_CLK_I and external pull-ups.
 */
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`include "twmt_defines.vh"
module twmt_master_tx #(
	parameter QTR_DIV = `TWMT_QTR_CYCLES
) (
	// Clock and reset
	input  wire       CORE_CLK_I,
	input  wire       SYS_RST_I,
	// Register port
	input  wire [1:0] ADDR_I,
	input  wire [7:0] WDATA_I,
	input  wire       WR_I,
	input  wire       RD_I,
	output reg  [7:0] RDATA_O,
	// Interrupt request
	output wire       IRQ_O,
	// Serial clock pin
	input  wire       SCL_I,
	output wire       SCL_O,
	output wire       SCL_OE_O,
	// Serial data pin
	input  wire       SDA_I,
	output wire       SDA_O,
	output wire       SDA_OE_O
);
	// ==========================================================
	// States
	localparam S_IDLE  = 7'h01;
	localparam S_WAIT  = 7'h02;
	localparam S_START = 7'h04;
	localparam S_HOLD  = 7'h08;
	localparam S_BYTE  = 7'h10;
	localparam S_ACK   = 7'h20;
	localparam S_STOP  = 7'h40;

	reg  [6:0] state_reg;
	reg  [1:0] phase_reg;
	reg  [2:0] bit_reg;
	reg  [7:0] shift_reg;
	reg  [7:0] data_reg;
	reg  [7:0] status_reg;
	reg        flag_reg;
	reg        ack_enable_reg;
	reg        start_reg;
	reg        stop_reg;
	reg        wcol_reg;
	reg        en_reg;
	reg        ie_reg;
	reg        addr_byte_reg;
	reg        rep_reg;
	reg        recv_mode_reg;
	reg        scl_oe_reg;
	reg        sda_oe_reg;
	reg        busy_reg;
	reg        scl_q_reg;
	reg        sda_q_reg;
	wire       tick;
	wire       step;
	wire       wr_ctrl;
	wire       wr_data;

	assign wr_ctrl  = WR_I && (ADDR_I == `TWMT_OFS_CTRL);
	assign wr_data  = WR_I && (ADDR_I == `TWMT_OFS_DATA);
	assign IRQ_O    = flag_reg & ie_reg;
	assign SCL_O    = 1'b0;
	assign SDA_O    = 1'b0;
	assign SCL_OE_O = scl_oe_reg;
	assign SDA_OE_O = sda_oe_reg;

	// ==========================================================
	// Bit timing
	twmt_tick_gen #(
		.DIV (QTR_DIV),
		.CW  (16)
	) u_tick (
		.clk_i  (CORE_CLK_I),
		.rst_i  (SYS_RST_I),
		.run_i  (en_reg),
		.tick_o (tick)
	);

	// Released clock must read high before moving on: slave stretching
	assign step = tick && (scl_oe_reg || SCL_I);

	// ==========================================================
	// Bus free monitor
	always @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			scl_q_reg <= 1'b1;
			sda_q_reg <= 1'b1;
			busy_reg  <= 1'b0;
		end else begin
			scl_q_reg <= SCL_I;
			sda_q_reg <= SDA_I;
			if (!en_reg)
				busy_reg <= 1'b0;
			else if (scl_q_reg && SCL_I && sda_q_reg && !SDA_I)
				busy_reg <= 1'b1;
			else if (scl_q_reg && SCL_I && !sda_q_reg && SDA_I)
				busy_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Read port: data valid only in the cycle after the strobe
	always @(posedge CORE_CLK_I) begin
		if (SYS_RST_I || !RD_I) begin
			RDATA_O <= 8'h00;
		end else if (ADDR_I == `TWMT_OFS_CTRL) begin
			RDATA_O <= {flag_reg, ack_enable_reg, start_reg, stop_reg,
				wcol_reg, en_reg, 1'b0, ie_reg};
		end else if (ADDR_I == `TWMT_OFS_STATUS) begin
			RDATA_O <= {status_reg[7:3], 3'h0};
		end else if (ADDR_I == `TWMT_OFS_DATA) begin
			RDATA_O <= data_reg;
		end else begin
			RDATA_O <= 8'h00;
		end
	end

	// ==========================================================
	// Registers and sequencer
	// Hardware flag set comes last so it wins over a same-cycle clear
	always @(posedge CORE_CLK_I) begin
		if (SYS_RST_I) begin
			state_reg      <= S_IDLE;
			phase_reg      <= 2'h0;
			bit_reg        <= 3'h7;
			shift_reg      <= 8'h00;
			data_reg       <= `TWMT_RST_DATA;
			status_reg     <= `TWMT_ST_NONE;
			flag_reg       <= 1'b0;
			ack_enable_reg <= 1'b0;
			start_reg      <= 1'b0;
			stop_reg       <= 1'b0;
			wcol_reg       <= 1'b0;
			en_reg         <= 1'b0;
			ie_reg         <= 1'b0;
			addr_byte_reg  <= 1'b0;
			rep_reg        <= 1'b0;
			recv_mode_reg  <= 1'b0;
			scl_oe_reg     <= 1'b0;
			sda_oe_reg     <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				if (WDATA_I[`TWMT_B_FLAG])
					flag_reg <= 1'b0;
				ack_enable_reg <= WDATA_I[`TWMT_B_ACK];
				start_reg      <= WDATA_I[`TWMT_B_START];
				stop_reg       <= WDATA_I[`TWMT_B_STOP];
				en_reg         <= WDATA_I[`TWMT_B_EN];
				ie_reg         <= WDATA_I[`TWMT_B_IE];
			end
			if (wr_data) begin
				if (flag_reg) begin
					data_reg <= WDATA_I;
					wcol_reg <= 1'b0;
				end else begin
					wcol_reg <= 1'b1;
				end
			end
			if (step)
				phase_reg <= phase_reg + 2'h1;
			if (!en_reg) begin
				// Disabled: release the bus and forget the transfer
				state_reg  <= S_IDLE;
				phase_reg  <= 2'h0;
				scl_oe_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
				rep_reg    <= 1'b0;
			end else begin
				case (state_reg)
				S_IDLE: begin
					phase_reg  <= 2'h0;
					scl_oe_reg <= 1'b0;
					sda_oe_reg <= 1'b0;
					// Also the released state after a lost arbitration
					if (start_reg && !flag_reg)
						state_reg <= S_WAIT;
				end
				S_WAIT: begin
					phase_reg <= 2'h0;
					if (step && !busy_reg) begin
						state_reg <= S_START;
						rep_reg   <= 1'b0;
					end
				end
				S_START: begin
					if (step) begin
						case (phase_reg)
						2'h0: sda_oe_reg <= 1'b0;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b1;
						default: begin
							scl_oe_reg    <= 1'b1;
							state_reg     <= S_HOLD;
							addr_byte_reg <= 1'b1;
							flag_reg      <= 1'b1;
							status_reg    <= rep_reg ? `TWMT_ST_RSTART
								: `TWMT_ST_START;
						end
						endcase
					end
				end
				S_HOLD: begin
					// Clock held low by the master until software clears
					phase_reg  <= 2'h0;
					scl_oe_reg <= 1'b1;
					if (!flag_reg) begin
						if (stop_reg) begin
							state_reg <= S_STOP;
						end else if (start_reg) begin
							state_reg <= S_START;
							rep_reg   <= 1'b1;
						end else begin
							state_reg <= S_BYTE;
							shift_reg <= data_reg;
							bit_reg   <= 3'h7;
						end
					end
				end
				S_BYTE: begin
					if (step) begin
						case (phase_reg)
						// Receive mode leaves the data line to the slave
						2'h0: sda_oe_reg <= ~shift_reg[7] & ~recv_mode_reg;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: begin
							if (shift_reg[7] && !SDA_I && !recv_mode_reg) begin
								// Another master pulled data low
								state_reg  <= S_IDLE;
								scl_oe_reg <= 1'b0;
								sda_oe_reg <= 1'b0;
								flag_reg   <= 1'b1;
								status_reg <= `TWMT_ST_LOST;
							end
						end
						default: begin
							scl_oe_reg <= 1'b1;
							shift_reg  <= {shift_reg[6:0], 1'b0};
							bit_reg    <= bit_reg - 3'h1;
							if (bit_reg == 3'h0)
								state_reg <= S_ACK;
						end
						endcase
					end
				end
				S_ACK: begin
					if (step) begin
						case (phase_reg)
						2'h0: sda_oe_reg <= 1'b0;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: begin
							if (!addr_byte_reg)
								status_reg <= SDA_I ? `TWMT_ST_D_NACK
									: `TWMT_ST_D_ACK;
							else if (data_reg[0])
								status_reg <= SDA_I ? `TWMT_ST_AR_NACK
									: `TWMT_ST_AR_ACK;
							else
								status_reg <= SDA_I ? `TWMT_ST_AW_NACK
									: `TWMT_ST_AW_ACK;
						end
						default: begin
							scl_oe_reg <= 1'b1;
							state_reg  <= S_HOLD;
							flag_reg   <= 1'b1;
							if (addr_byte_reg)
								recv_mode_reg <= data_reg[0];
							addr_byte_reg <= 1'b0;
						end
						endcase
					end
				end
				S_STOP: begin
					if (step) begin
						case (phase_reg)
						2'h0: sda_oe_reg <= 1'b1;
						2'h1: scl_oe_reg <= 1'b0;
						2'h2: sda_oe_reg <= 1'b0;
						default: begin
							stop_reg      <= 1'b0;
							status_reg    <= `TWMT_ST_NONE;
							recv_mode_reg <= 1'b0;
							// Start still requested: STOP then fresh START
							state_reg <= start_reg ? S_WAIT : S_IDLE;
						end
						endcase
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
				endcase
			end
		end
	end
endmodule // twmt_master_tx

/* twmt_props.sv */
/* Checker for the two-wire master: register port and wire relations.
   Assumes binding onto twmt_master_tx and pull-ups on both lines. */
`timescale 1ns/1ps
module twmt_props (
	// Clock, reset and register port
	input wire       CORE_CLK_I,
	input wire       SYS_RST_I,
	input wire [1:0] ADDR_I,
	input wire [7:0] WDATA_I,
	input wire       WR_I,
	input wire       RD_I,
	input wire [7:0] RDATA_O,
	input wire       IRQ_O,
	// Wire levels and enables
	input wire       SCL_I,
	input wire       SCL_OE_O,
	input wire       SDA_I,
	input wire       SDA_OE_O
);
	// ==========================================
	// Shadow of enables and foreign bus use
	reg en_reg, ie_reg, busy_reg, scl_reg, sda_reg;
	always @(posedge CORE_CLK_I) begin
		scl_reg <= SCL_I;
		sda_reg <= SDA_I;
		if (SYS_RST_I) begin
			en_reg   <= 1'b0;
			ie_reg   <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			if (WR_I && ADDR_I == 2'h0) begin
				en_reg <= WDATA_I[2];
				ie_reg <= WDATA_I[0];
			end
			// Only a START that this master did not make marks the bus busy
			if (scl_reg && SCL_I && sda_reg && !SDA_I && !SDA_OE_O)
				busy_reg <= 1'b1;
			else if (scl_reg && SCL_I && !sda_reg && SDA_I)
				busy_reg <= 1'b0;
		end
	end
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// ==========================================
	// Assertions
	chk_status_low: assert property (RD_I && ADDR_I == 2'h1 |=> RDATA_O[2:0] == 3'h0)
		else $error("status low bits not zero");
	chk_status_code: assert property (RD_I && ADDR_I == 2'h1 |=> RDATA_O inside
		{8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48, 8'hf8})
		else $error("unknown status code");
	chk_off_idle: assert property (!en_reg && !$past(en_reg) |-> !SCL_OE_O && !SDA_OE_O)
		else $error("bus driven while disabled");
	chk_start_free: assert property ($rose(SDA_OE_O) && SCL_I |-> !busy_reg)
		else $error("start issued on busy bus");
	chk_flag_clear: assert property (WR_I && ADDR_I == 2'h0 && WDATA_I[7] && IRQ_O |=> !IRQ_O)
		else $error("flag not cleared by write");
	chk_wcol_set: assert property (WR_I && ADDR_I == 2'h2 && !IRQ_O && ie_reg
		##2 RD_I && ADDR_I == 2'h0 |=> RDATA_O[3])
		else $error("write collision not flagged");
	chk_hold_stall: assert property (IRQ_O && SCL_OE_O && !WR_I |=> SCL_OE_O && $stable(SDA_OE_O))
		else $error("transfer moved while flag set");
	chk_irq_flag: assert property (RD_I && ADDR_I == 2'h0 |=> (RDATA_O[7] & RDATA_O[0]) == $past(IRQ_O))
		else $error("irq differs from flag and enable");
	cov_flag: cover property ($rose(IRQ_O));
	cov_busy: cover property (busy_reg && en_reg);
	cov_wcol: cover property (RD_I && ADDR_I == 2'h0 ##1 RDATA_O[3]);
endmodule // twmt_props

bind twmt_master_tx twmt_props u_props (.CORE_CLK_I, .SYS_RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I,
	.RDATA_O, .IRQ_O, .SCL_I, .SCL_OE_O, .SDA_I, .SDA_OE_O);

/* twmt_slave_model.sv */
/* Slave receiver model: takes bytes MSB first, answers the ninth bit.
   Assumes sampled wire levels with pull-ups; it never stretches the clock. */
`timescale 1ns/1ps
module twmt_slave_model (
	// Clock and wire
	input  wire       clk_i,
	input  wire       scl_i,
	input  wire       sda_i,
	// Behaviour and result
	input  wire       ack_en_i,
	output reg        sda_pull_o = 1'b0,
	output reg  [7:0] rx_byte_o = 8'h00
);
	reg       scl_reg = 1'b1;
	reg       sda_reg = 1'b1;
	reg [3:0] cnt_reg = 4'h0;
	reg [7:0] sh_reg = 8'h00;
	always @(posedge clk_i) begin
		scl_reg <= scl_i;
		sda_reg <= sda_i;
		if (scl_i && scl_reg && sda_reg && !sda_i) begin
			// The START's own clock fall is not a data bit
			cnt_reg <= 4'hf;
			sda_pull_o <= 1'b0;
		end else if (scl_i && !scl_reg && cnt_reg < 4'h8) begin
			sh_reg <= {sh_reg[6:0], sda_i};
		end else if (!scl_i && scl_reg) begin
			// Ack only from the eighth falling clock to the ninth
			cnt_reg <= (cnt_reg == 4'h8 || cnt_reg == 4'hf) ? 4'h0 : cnt_reg + 4'h1;
			sda_pull_o <= (cnt_reg == 4'h7) && ack_en_i;
			if (cnt_reg == 4'h7)
				rx_byte_o <= sh_reg;
		end
	end
endmodule // twmt_slave_model

/* tb_top.sv */
/* Testbench for the two-wire master: register tasks and scenarios.
   Assumes a quarter-bit divider of 4 and pull-ups on both lines. */
`timescale 1ns/1ps
module tb_top;
	reg        clk = 1'b0;
	reg        rst = 1'b1;
	reg  [1:0] addr = 2'h0;
	reg  [7:0] wdata = 8'h00;
	reg        wr = 1'b0;
	reg        rd = 1'b0;
	reg        ack_en = 1'b1;
	reg        tb_low = 1'b0;
	reg  [7:0] v;
	wire [7:0] rdata;
	wire [7:0] rx;
	wire       irq, scl_oe, sda_oe, pull;
	wire       scl_do, sda_do;
	wire       scl = !scl_oe;
	wire       sda = !(sda_oe | pull | tb_low);
	integer    num_errors = 0;
	integer    samples_checked = 0;
	integer    cyc = 0;
	always #4 clk = !clk;
	twmt_master_tx #(.QTR_DIV(4)) dut (.CORE_CLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .SCL_I(scl),
		.SCL_O(scl_do), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_do), .SDA_OE_O(sda_oe));
	twmt_slave_model slave (.clk_i(clk), .scl_i(scl), .sda_i(sda), .ack_en_i(ack_en),
		.sda_pull_o(pull), .rx_byte_o(rx));
	// ==========================================
	// Shared tasks
	task test_done;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors = num_errors + 1;
			test_done;
		end
	end
	task chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask
	task wreg(input [1:0] a, input [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rreg(input [1:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// Write control, poll the flag with a bound, then judge the status
	task step(input [7:0] ctl, input [7:0] st);
		integer i;
		wreg(2'h0, ctl);
		v = 8'h00;
		for (i = 0; i < 2000 && v[7] !== 1'b1; i = i + 1)
			rreg(2'h0);
		rreg(2'h1);
		chk("status", v, st);
		chk("irq", {7'h0, irq}, 8'h01);
	endtask
	// ==========================================
	// Scenarios
	task t_reset;
		rreg(2'h0);
		chk("ctrl", v, 8'h00);
		rreg(2'h1);
		chk("status", v, 8'hf8);
		rreg(2'h2);
		chk("data", v, 8'hff);
		rreg(2'h3);
		chk("unmapped", v, 8'h00);
		chk("drive", {6'h0, scl_do, sda_do}, 8'h00);
		wreg(2'h0, 8'ha1);
		repeat (200) @(posedge clk);
		chk("sda_oe", {7'h0, sda_oe}, 8'h00);
		chk("irq", {7'h0, irq}, 8'h00);
		$display("t_reset done");
	endtask
	task t_xfer;
		wreg(2'h0, 8'h05);
		tb_low <= 1'b1;
		wreg(2'h0, 8'ha5);
		repeat (200) @(posedge clk);
		chk("sda_oe", {7'h0, sda_oe}, 8'h00);
		tb_low <= 1'b0;
		step(8'ha5, 8'h08);
		wreg(2'h2, 8'ha0);
		step(8'h85, 8'h18);
		chk("rx", rx, 8'ha0);
		wreg(2'h2, 8'h3c);
		wreg(2'h0, 8'h85);
		wreg(2'h2, 8'h55);
		rreg(2'h0);
		chk("wcol", {7'h0, v[3]}, 8'h01);
		step(8'h05, 8'h28);
		chk("rx", rx, 8'h3c);
		ack_en <= 1'b0;
		wreg(2'h2, 8'hc3);
		step(8'h85, 8'h30);
		ack_en <= 1'b1;
		$display("t_xfer done");
	endtask
	task t_rstart;
		step(8'ha5, 8'h10);
		ack_en <= 1'b0;
		wreg(2'h2, 8'ha2);
		step(8'h85, 8'h20);
		ack_en <= 1'b1;
		step(8'hb5, 8'h08);
		rreg(2'h0);
		chk("stop", {7'h0, v[4]}, 8'h00);
		wreg(2'h2, 8'ha1);
		step(8'h85, 8'h40);
		chk("rx", rx, 8'ha1);
		wreg(2'h0, 8'h95);
		repeat (100) @(posedge clk);
		rreg(2'h0);
		chk("stop", {7'h0, v[4]}, 8'h00);
		chk("oe", {6'h0, scl_oe, sda_oe}, 8'h00);
		$display("t_rstart done");
	endtask
	task t_lost;
		step(8'ha5, 8'h08);
		wreg(2'h2, 8'h80);
		tb_low <= 1'b1;
		step(8'h85, 8'h38);
		wreg(2'h0, 8'h85);
		repeat (50) @(posedge clk);
		chk("oe", {6'h0, scl_oe, sda_oe}, 8'h00);
		// Bus still held low by the other master: START must wait
		wreg(2'h0, 8'ha5);
		repeat (50) @(posedge clk);
		chk("sda_oe", {7'h0, sda_oe}, 8'h00);
		tb_low <= 1'b0;
		step(8'ha5, 8'h08);
		wreg(2'h0, 8'h95);
		repeat (100) @(posedge clk);
		$display("t_lost done");
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_xfer;
		t_rstart;
		t_lost;
		test_done;
	end
endmodule // tb_top
